// File: verilog/irct_top.sv
// byte timer and word timer with edge-capture demodulation
// assumes synchronous pin inputs and a one-cycle strobe register port
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
`include "irct_regs.svh"

// Behaviour
// RQ1 - prescale code 11 runs the byte timer at clock divided by eight
// RQ2 - codes 00, 01, 10 give clock, half, quarter; 00 after reset
// RQ3 - control bit 2 gates the capture interrupt
// RQ4 - control bit 1 gates the timeout interrupt
// RQ5 - control bit 0 puts byte timer output on the shared pin, else port data
// RQ6 - reset clears control; stop recovery keeps prescale, masks and timeout flag
// RQ7 - writing run 1 starts the byte timer, 0 stops it
// RQ8 - at terminal count reload in modulo mode, stop in single pass mode
// RQ9 - terminal count sets the timeout flag; only writing 1 clears it
// RQ10 - software clears the timeout flag before using the timers
// RQ11 - first count after enable may be short; enable not aligned to prescale
// RQ12 - software must not write back a set flag it wants to keep
// RQ13 - software avoids writing hold registers while they load the counter
// RQ14 - software never loads the word timer with one
// RQ15 - initial zero runs the full range; wrap to FFFF is no timeout
// RQ16 - software loads both word hold bytes with FF before demodulation
// RQ17 - first selected edge captures, reloads and starts the word timer
// RQ18 - with option 0 each later edge captures the complemented count
// RQ19 - each capture sets an edge flag and interrupts when enabled
// RQ20 - after each capture the word timer reloads FFFF and counts on
// RQ21 - software disables timers before switching transmit and demodulation
// RQ22 - writing 0 leaves timeout flag; timeout interrupt with the flag set
module irct_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic stop_recover,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pins
  input wire logic carrier_in,
  input wire logic port_data,
  output logic shared_out_pin,
  output logic word_out_pin,
  // interrupt requests
  output logic irq_timeout,
  output logic irq_capture
);

  irct_pkg::irct_req_t req;
  irct_pkg::irct_ctrl_t ctrl;
  irct_pkg::irct_wt_state_t wt_state;
  irct_pkg::irct_wt_state_t next_wt_state;
  logic [7:0] mode_ctrl;
  logic [7:0] word_ctrl;
  logic [7:0] byte_hold;
  logic [7:0] word_hold_low;
  logic [7:0] word_hold_high;
  logic [7:0] capture_low_byte;
  logic [7:0] capture_high_byte;
  logic [2:0] div_cnt;
  logic ps_tick;
  logic [7:0] byte_count;
  logic byte_out;
  logic byte_tc;
  logic [15:0] word_count;
  logic word_start;
  logic word_run_q;
  logic carrier_q;
  logic rise;
  logic fall;
  logic sel_edge;
  logic capture;
  logic wr_byte_ctrl;
  logic clr_tmo;
  logic word_tc;

  // bundle the port request
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign wr_byte_ctrl = req.wr && (req.addr == `IRCT_BYTE_CTRL);
  assign clr_tmo = wr_byte_ctrl && req.wdata[`IRCT_B_TMO]; // RQ22

  // free-running prescale divider, enable not aligned to it
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      div_cnt <= 3'h0;
    end else begin
      div_cnt <= div_cnt + 3'h1; // RQ11
    end
  end

  // pick the count tick from the prescale code
  always_comb begin
    unique case (ctrl.prescale)
      `IRCT_PS_DIV1: ps_tick = 1'b1; // RQ2
      `IRCT_PS_DIV2: ps_tick = div_cnt[0]; // RQ2
      `IRCT_PS_DIV4: ps_tick = &div_cnt[1:0]; // RQ2
      `IRCT_PS_DIV8: ps_tick = (div_cnt == `IRCT_DIV_MAX); // RQ1
    endcase
  end

  assign byte_tc = ctrl.run && ps_tick && (byte_count == `IRCT_ZERO8);

  // byte timer control register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ctrl <= '0; // RQ6
    end else if (stop_recover) begin
      ctrl.run <= 1'b0; // RQ6
      ctrl.single <= 1'b0;
      ctrl.pin_sel <= 1'b0;
      ctrl.timeout <= ctrl.timeout || byte_tc;
    end else begin
      if (wr_byte_ctrl) begin
        ctrl.run <= req.wdata[`IRCT_B_RUN]; // RQ7
        ctrl.single <= req.wdata[`IRCT_B_SINGLE];
        ctrl.prescale <= req.wdata[`IRCT_B_PS_HI:`IRCT_B_PS_LO]; // RQ1
        ctrl.cap_mask <= req.wdata[`IRCT_B_CAPM]; // RQ3
        ctrl.tmo_mask <= req.wdata[`IRCT_B_TMOM]; // RQ4
        ctrl.pin_sel <= req.wdata[`IRCT_B_PINSEL]; // RQ5
      end else if (byte_tc && ctrl.single) begin
        ctrl.run <= 1'b0; // RQ8
      end
      // set wins over the write-one clear
      if (byte_tc) begin
        ctrl.timeout <= 1'b1; // RQ9
      end else if (clr_tmo) begin
        ctrl.timeout <= 1'b0; // RQ9
      end
    end
  end

  // byte timer counter and output toggle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      byte_count <= `IRCT_ZERO8;
      byte_out <= 1'b0;
    end else if (wr_byte_ctrl && req.wdata[`IRCT_B_RUN] && !ctrl.run) begin
      byte_count <= byte_hold; // RQ7
    end else if (byte_tc) begin
      byte_count <= byte_hold; // RQ8
      byte_out <= ~byte_out;
    end else if (ctrl.run && ps_tick) begin
      byte_count <= byte_count - `IRCT_ONE8;
    end
  end

  // hold registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      byte_hold <= `IRCT_ZERO8;
      word_hold_low <= `IRCT_ZERO8;
      word_hold_high <= `IRCT_ZERO8;
    end else if (req.wr) begin
      if (req.addr == `IRCT_BYTE_HOLD) begin
        byte_hold <= req.wdata;
      end
      if (req.addr == `IRCT_WORD_HOLD_LO) begin
        word_hold_low <= req.wdata;
      end
      if (req.addr == `IRCT_WORD_HOLD_HI) begin
        word_hold_high <= req.wdata;
      end
    end
  end

  // word timer control register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      word_ctrl <= `IRCT_ZERO8;
    end else if (stop_recover) begin
      word_ctrl[`IRCT_W_RUN] <= 1'b0;
    end else if (req.wr && (req.addr == `IRCT_WORD_CTRL)) begin
      word_ctrl <= req.wdata;
    end
  end

  // carrier edge detection
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      carrier_q <= 1'b0;
      word_run_q <= 1'b0;
    end else begin
      carrier_q <= carrier_in;
      word_run_q <= word_ctrl[`IRCT_W_RUN];
    end
  end

  assign rise = carrier_in && !carrier_q;
  assign fall = !carrier_in && carrier_q;
  assign sel_edge = (rise && mode_ctrl[`IRCT_M_RISE_SEL]) ||
                    (fall && mode_ctrl[`IRCT_M_FALL_SEL]); // RQ17
  assign word_start = word_ctrl[`IRCT_W_RUN] && !word_run_q;
  assign capture = word_ctrl[`IRCT_W_DEMOD] && sel_edge &&
                   ((wt_state == irct_pkg::IRCT_WT_ARMED) ||
                    ((wt_state == irct_pkg::IRCT_WT_COUNT) &&
                     !word_ctrl[`IRCT_W_OPT])); // RQ18
  assign word_tc = (wt_state == irct_pkg::IRCT_WT_COUNT) &&
                   !word_ctrl[`IRCT_W_DEMOD] &&
                   (word_count == `IRCT_ONE16); // RQ15

  // word timer sequencing
  always_comb begin
    next_wt_state = wt_state;
    unique case (wt_state)
      irct_pkg::IRCT_WT_IDLE: begin
        if (word_start && word_ctrl[`IRCT_W_DEMOD]) begin
          next_wt_state = irct_pkg::IRCT_WT_ARMED;
        end else if (word_start) begin
          next_wt_state = irct_pkg::IRCT_WT_COUNT;
        end
      end
      irct_pkg::IRCT_WT_ARMED: begin
        if (sel_edge) begin
          next_wt_state = irct_pkg::IRCT_WT_COUNT; // RQ17
        end
      end
      irct_pkg::IRCT_WT_COUNT: begin
        next_wt_state = irct_pkg::IRCT_WT_COUNT;
      end
      default: next_wt_state = irct_pkg::IRCT_WT_IDLE;
    endcase
    if (!word_ctrl[`IRCT_W_RUN]) begin
      next_wt_state = irct_pkg::IRCT_WT_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wt_state <= irct_pkg::IRCT_WT_IDLE;
    end else begin
      wt_state <= next_wt_state;
    end
  end

  // word counter: loads, captures and wraps
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      word_count <= `IRCT_ZERO16;
      word_out_pin <= 1'b0;
    end else if (word_start || (capture && wt_state == irct_pkg::IRCT_WT_ARMED)) begin
      word_count <= {word_hold_high, word_hold_low}; // RQ17
    end else if (capture) begin
      word_count <= `IRCT_FULL16; // RQ20
    end else if (word_tc) begin
      word_count <= {word_hold_high, word_hold_low};
      word_out_pin <= ~word_out_pin;
    end else if (wt_state == irct_pkg::IRCT_WT_COUNT) begin
      word_count <= word_count - `IRCT_ONE16; // RQ15
    end
  end

  // capture bytes
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      capture_low_byte <= `IRCT_ZERO8;
      capture_high_byte <= `IRCT_ZERO8;
    end else if (capture) begin
      capture_low_byte <= ~word_count[7:0]; // RQ18
      capture_high_byte <= ~word_count[15:8]; // RQ18
    end
  end

  // mode control with write-one-clear edge flags
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mode_ctrl <= `IRCT_ZERO8;
    end else begin
      if (req.wr && (req.addr == `IRCT_MODE_CTRL)) begin
        mode_ctrl[7:2] <= req.wdata[7:2];
        if (req.wdata[`IRCT_M_RISE_FLAG]) begin
          mode_ctrl[`IRCT_M_RISE_FLAG] <= 1'b0;
        end
        if (req.wdata[`IRCT_M_FALL_FLAG]) begin
          mode_ctrl[`IRCT_M_FALL_FLAG] <= 1'b0;
        end
      end
      // set wins over clear
      if (capture && rise) begin
        mode_ctrl[`IRCT_M_RISE_FLAG] <= 1'b1; // RQ19
      end
      if (capture && fall) begin
        mode_ctrl[`IRCT_M_FALL_FLAG] <= 1'b1; // RQ19
      end
    end
  end

  // interrupt requests and pin mux
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_timeout <= 1'b0;
      irq_capture <= 1'b0;
      shared_out_pin <= 1'b0;
    end else begin
      irq_timeout <= byte_tc && ctrl.tmo_mask; // RQ4 RQ22
      irq_capture <= capture && ctrl.cap_mask && word_ctrl[`IRCT_W_CAPE]; // RQ3 RQ19
      shared_out_pin <= ctrl.pin_sel ? byte_out : port_data; // RQ5
    end
  end

  // registered read data, zero for unmapped
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= `IRCT_ZERO8;
    end else if (req.rd) begin
      unique case (req.addr)
        `IRCT_BYTE_CTRL: reg_rdata <= ctrl;
        `IRCT_MODE_CTRL: reg_rdata <= mode_ctrl;
        `IRCT_WORD_CTRL: reg_rdata <= word_ctrl;
        `IRCT_BYTE_HOLD: reg_rdata <= byte_hold;
        `IRCT_WORD_HOLD_LO: reg_rdata <= word_hold_low;
        `IRCT_WORD_HOLD_HI: reg_rdata <= word_hold_high;
        `IRCT_CAPT_LO: reg_rdata <= capture_low_byte;
        `IRCT_CAPT_HI: reg_rdata <= capture_high_byte;
        default: reg_rdata <= `IRCT_ZERO8;
      endcase
    end else begin
      reg_rdata <= `IRCT_ZERO8;
    end
  end

endmodule

// File: verilog/irct_regs.svh
// register offsets, field positions and reset values of the timer block
// assumes byte-wide registers on a plain strobe port
`ifndef IRCT_REGS_SVH
`define IRCT_REGS_SVH

// offsets
`define IRCT_BYTE_CTRL 8'h00
`define IRCT_MODE_CTRL 8'h01
`define IRCT_WORD_CTRL 8'h02
`define IRCT_BYTE_HOLD 8'h04
`define IRCT_WORD_HOLD_LO 8'h06
`define IRCT_WORD_HOLD_HI 8'h07
`define IRCT_CAPT_LO 8'h08
`define IRCT_CAPT_HI 8'h09

// byte timer control fields
`define IRCT_B_RUN 7
`define IRCT_B_SINGLE 6
`define IRCT_B_TMO 5
`define IRCT_B_PS_HI 4
`define IRCT_B_PS_LO 3
`define IRCT_B_CAPM 2
`define IRCT_B_TMOM 1
`define IRCT_B_PINSEL 0

// mode control fields
`define IRCT_M_FALL_SEL 5
`define IRCT_M_RISE_SEL 4
`define IRCT_M_FALL_FLAG 1
`define IRCT_M_RISE_FLAG 0

// word timer control fields
`define IRCT_W_RUN 7
`define IRCT_W_OPT 6
`define IRCT_W_CAPE 2
`define IRCT_W_DEMOD 1

// prescaler codes
`define IRCT_PS_DIV1 2'h0
`define IRCT_PS_DIV2 2'h1
`define IRCT_PS_DIV4 2'h2
`define IRCT_PS_DIV8 2'h3

// constants
`define IRCT_ZERO8 8'h00
`define IRCT_ZERO16 16'h0000
`define IRCT_ONE8 8'h01
`define IRCT_ONE16 16'h0001
`define IRCT_FULL16 16'hFFFF
`define IRCT_DIV_MAX 3'h7

`endif

// File: verilog/irct_pkg.sv
// types shared by the timer block
// assumes the register header for field widths
package irct_pkg;

  // word timer sequencing, one-hot
  typedef enum logic [2:0] {
    IRCT_WT_IDLE = 3'h1,
    IRCT_WT_ARMED = 3'h2,
    IRCT_WT_COUNT = 3'h4
  } irct_wt_state_t;

  // byte timer control register layout
  typedef struct packed {
    logic run;
    logic single;
    logic timeout;
    logic [1:0] prescale;
    logic cap_mask;
    logic tmo_mask;
    logic pin_sel;
  } irct_ctrl_t;

  // one register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } irct_req_t;

endpackage

// File: tb/irct_monitor.sv
// port assertions of the timer block
// assumes a bind onto irct_top; sees its ports only
`timescale 1ns/100ps
module irct_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic stop_recover,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins and requests
  input wire logic carrier_in,
  input wire logic port_data,
  input wire logic shared_out_pin,
  input wire logic irq_timeout,
  input wire logic irq_capture
);
  logic [7:0] ctrl;
  logic wcap;
  logic flag;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // shadow of control bytes; stop recovery drops run, single, pin select
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ctrl <= 8'h00;
    end else if (reg_wr && reg_addr == 8'h00) begin
      ctrl <= reg_wdata;
    end else if (stop_recover) begin
      ctrl <= ctrl & 8'h3E;
    end
  end
  // shadow of word capture enable
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wcap <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h02) begin
      wcap <= reg_wdata[2];
    end
  end
  // timeout flag as seen through the request; lags the real flag
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      flag <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h00 && reg_wdata[5]) begin
      flag <= 1'b0;
    end else if (irq_timeout) begin
      flag <= 1'b1;
    end
  end
  sequence s_flag_read;
    reg_rd && reg_addr == 8'h00 && flag;
  endsequence
  sequence s_pin_edge;
    $past(carrier_in) != $past(carrier_in, 2);
  endsequence
  a_reset_quiet: assert property ($rose(rst_b) |-> reg_rdata == 8'h00 && !irq_timeout)
    else $error("outputs not quiet after reset");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_tmo_mask: assert property (irq_timeout |-> $past(ctrl[1]))
    else $error("timeout request while masked");
  a_cap_mask: assert property (irq_capture |-> $past(ctrl[2] && wcap))
    else $error("capture request while masked");
  a_pin_port: assert property ($past(rst_b) && !$past(ctrl[0]) |-> shared_out_pin == $past(port_data))
    else $error("shared pin not following port data");
  a_tmo_flag: assert property (s_flag_read |=> reg_rdata[5])
    else $error("timeout flag lost");
  a_single_stop: assert property (irq_timeout && $past(ctrl[6]) |=> !irq_timeout)
    else $error("single pass kept counting");
  a_cap_edge: assert property (irq_capture |-> s_pin_edge)
    else $error("capture without pin edge");
endmodule

// File: tb/irct_carrier_src.sv
// carrier source at the demodulator input pin
// assumes the bench enables it once capture is set up
`timescale 1ns/100ps
module irct_carrier_src (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // control
  input wire logic go,
  input wire logic [7:0] half,
  // pin
  output logic carrier_in
);
  logic [7:0] cnt;
  // square wave while enabled, low otherwise
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !go) begin
      cnt <= 8'h00;
      carrier_in <= 1'b0;
    end else if (cnt == half - 8'h01) begin
      cnt <= 8'h00;
      carrier_in <= !carrier_in;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// File: tb/tb_irct_top.sv
// self-checking bench of the timer block
// assumes the monitor and carrier source are compiled first
`timescale 1ns/100ps
module tb_irct_top;
  typedef struct {logic [1:0] ps; int per;} irct_row_t;
  irct_row_t rows [4] = '{'{2'h0, 4}, '{2'h1, 8}, '{2'h2, 16}, '{2'h3, 32}};
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic stop_recover = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic port_data = 1'b0;
  logic go = 1'b0;
  logic [7:0] reg_rdata;
  logic carrier_in, shared_out_pin, word_out_pin, irq_timeout, irq_capture;
  int err_total = 0;
  int n_checks = 0;
  int p;
  irct_top uut (.ref_clk(ref_clk), .rst_b(rst_b), .stop_recover(stop_recover),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .carrier_in(carrier_in), .port_data(port_data),
    .shared_out_pin(shared_out_pin), .word_out_pin(word_out_pin), .irq_timeout(irq_timeout),
    .irq_capture(irq_capture));
  irct_carrier_src src (.ref_clk(ref_clk), .rst_b(rst_b), .go(go), .half(8'h0A),
    .carrier_in(carrier_in));
  // clock
  initial forever #10 ref_clk = ~ref_clk;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, exp);
  endtask
  // pulses of one request line over n cycles
  task automatic cnt_irq(input int n, input bit cap, output int c);
    c = 0;
    repeat (n) begin
      @(negedge ref_clk);
      if ((cap ? irq_capture : irq_timeout) === 1'b1) c++;
    end
  endtask
  // level changes of one output pin over n cycles
  task automatic flips(input int n, input bit wsel, output int c);
    logic last;
    c = 0;
    last = wsel ? word_out_pin : shared_out_pin;
    repeat (n) begin
      @(negedge ref_clk);
      if ((wsel ? word_out_pin : shared_out_pin) !== last) c++;
      last = wsel ? word_out_pin : shared_out_pin;
    end
  endtask
  // cycles between two timeout pulses
  task automatic period(output int q);
    int i;
    q = 0;
    for (i = 0; i < 300 && irq_timeout !== 1'b1; i++) @(negedge ref_clk);
    do begin
      @(negedge ref_clk);
      q++;
    end while (irq_timeout !== 1'b1 && q < 300);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(8'h00, 8'h00);
    rd(8'h0F, 8'h00);
    wr(8'h04, 8'h03);
    // prescale codes: reload period is (hold + 1) times the divider
    foreach (rows[k]) begin
      wr(8'h00, {3'h4, rows[k].ps, 3'h2});
      period(p);
      chk(8'(p), 8'(rows[k].per));
      wr(8'h00, 8'h02);
    end
    cnt_irq(40, 1'b0, p);
    chk(8'(p), 8'h00);
    rd(8'h00, 8'h22);
    wr(8'h00, 8'h22);
    rd(8'h00, 8'h02);
    wr(8'h00, 8'hC2);
    cnt_irq(40, 1'b0, p);
    chk(8'(p), 8'h01);
    rd(8'h00, 8'h62);
    wr(8'h00, 8'hA0);
    port_data <= 1'b1;
    cnt_irq(20, 1'b0, p);
    chk(8'(p), 8'h00);
    rd(8'h00, 8'hA0);
    wr(8'h00, 8'h20);
    @(negedge ref_clk);
    chk({7'h00, shared_out_pin}, 8'h01);
    wr(8'h00, 8'hDF);
    @(posedge ref_clk);
    stop_recover <= 1'b1;
    @(posedge ref_clk);
    stop_recover <= 1'b0;
    rd(8'h00, 8'h1E);
    wr(8'h00, 8'h24);
    // demodulation with rising edges every 20 cycles
    wr(8'h06, 8'hFF);
    wr(8'h07, 8'hFF);
    wr(8'h01, 8'h10);
    wr(8'h02, 8'h86);
    go <= 1'b1;
    repeat (70) @(negedge ref_clk);
    rd(8'h08, 8'h13);
    rd(8'h09, 8'h00);
    rd(8'h01, 8'h11);
    cnt_irq(40, 1'b1, p);
    chk(8'(p), 8'h02);
    go <= 1'b0;
    // transmit word timer: hold 3 reloads every 3 cycles
    wr(8'h02, 8'h00);
    wr(8'h06, 8'h03);
    wr(8'h07, 8'h00);
    wr(8'h02, 8'h80);
    repeat (8) @(negedge ref_clk);
    flips(30, 1'b1, p);
    chk(8'(p), 8'h0A);
    // byte timer output routed to the shared pin, toggles every 4 cycles
    wr(8'h00, 8'h81);
    repeat (8) @(negedge ref_clk);
    flips(40, 1'b0, p);
    chk(8'(p), 8'h0A);
    wrap_up();
  end
endmodule
bind irct_top irct_monitor mon (.ref_clk(ref_clk), .rst_b(rst_b), .stop_recover(stop_recover),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .carrier_in(carrier_in), .port_data(port_data),
  .shared_out_pin(shared_out_pin), .irq_timeout(irq_timeout), .irq_capture(irq_capture));
